// *** include/scrb_pkg.sv ***
// constants of the sensor conditioner register bank
`default_nettype none
package scrb_pkg;
  // register pages
  localparam logic [2:0] PAGE_CTRL = 3'h0;
  localparam logic [2:0] PAGE_CONV = 3'h2;
  localparam logic [2:0] PAGE_NVM = 3'h5;
  // control and status offsets
  localparam logic [7:0] OFS_MODE = 8'h0C;
  localparam logic [7:0] OFS_PRES_LO = 8'h20;
  localparam logic [7:0] OFS_PRES_HI = 8'h21;
  localparam logic [7:0] OFS_TEMP_LO = 8'h24;
  localparam logic [7:0] OFS_TEMP_HI = 8'h25;
  localparam logic [7:0] OFS_CODE_LO = 8'h30;
  localparam logic [7:0] OFS_CODE_HI = 8'h31;
  localparam logic [7:0] OFS_DAC_CFG = 8'h39;
  localparam logic [7:0] OFS_OP_STAGE = 8'h3B;
  localparam logic [7:0] OFS_BRIDGE = 8'h46;
  localparam logic [7:0] OFS_PGAIN = 8'h47;
  localparam logic [7:0] OFS_TGAIN = 8'h48;
  localparam logic [7:0] OFS_TCHAN = 8'h4C;
  localparam logic [7:0] OFS_FAULT = 8'h5A;
  localparam logic [7:0] OFS_TEST = 8'h67;
  localparam logic [7:0] OFS_WINDOW_END = 8'h7F;
  localparam logic [7:0] OFS_CACHE = 8'h80;
  localparam logic [7:0] OFS_CACHE_END = 8'h87;
  localparam logic [7:0] OFS_PAGE = 8'h88;
  localparam logic [7:0] OFS_PROG = 8'h89;
  localparam logic [7:0] OFS_CHECKSUM = 8'h8A;
  localparam logic [7:0] OFS_BUSY = 8'h8B;
  // field positions
  localparam int MODE_W = 2;
  localparam int CODE_W = 14;
  localparam int PAGE_W = 4;
  localparam int PROG_BURN_BIT = 0;
  localparam int PROG_WIPE_BIT = 1;
  localparam int PROG_BOTH_BIT = 2;
  localparam int PROG_FIXED_BIT = 3;
  localparam int TEST_SE_BIT = 3;
  localparam int TEST_DAC_BIT = 0;
  localparam logic [7:0] TEST_MASK = 8'h09;
  localparam logic [7:0] FAULT_MASK = 8'hF7;
  localparam logic [MODE_W-1:0] MODE_EXECUTE = 2'h0;
  // nonvolatile byte addresses (page * 8 + byte)
  localparam logic [6:0] NV_DAC_CFG = 7'h20;
  localparam logic [6:0] NV_OP_STAGE = 7'h21;
  localparam logic [6:0] NV_BRIDGE = 7'h22;
  localparam logic [6:0] NV_PGAIN = 7'h23;
  localparam logic [6:0] NV_TGAIN = 7'h24;
  localparam logic [6:0] NV_TCHAN = 7'h25;
  localparam logic [6:0] NV_TEMPERATURE_SINGLE_ENDED_SELECT = 7'h28;
  localparam logic [6:0] NV_NORM_LO = 7'h29;
  localparam logic [6:0] NV_NORM_HI = 7'h2B;
  localparam logic [6:0] NV_CLAMP_LO = 7'h2D;
  localparam logic [6:0] NV_CLAMP_HI = 7'h2F;
  localparam logic [6:0] NV_DIAG_EN = 7'h31;
  localparam logic [6:0] NV_LOCK = 7'h32;
  localparam logic [6:0] NV_FAULT_SETUP = 7'h33;
  localparam logic [6:0] NV_FAULT_SELECT = 7'h34;
  localparam logic [6:0] NV_SERIAL = 7'h38;
  localparam logic [6:0] NV_CHECKSUM = 7'h7F;
  // default contents
  localparam logic [7:0] DEF_DAC_CFG = 8'h00;
  localparam logic [7:0] DEF_OP_STAGE = 8'h08;
  localparam logic [7:0] DEF_BRIDGE = 8'h00;
  localparam logic [7:0] DEF_PGAIN = 8'h00;
  localparam logic [7:0] DEF_TGAIN = 8'h00;
  localparam logic [7:0] DEF_TCHAN = 8'h40;
  localparam logic [15:0] DEF_NORM_LO = 16'h0667;
  localparam logic [15:0] DEF_NORM_HI = 16'h399A;
  localparam logic [15:0] DEF_CLAMP_LO = 16'h0334;
  localparam logic [15:0] DEF_CLAMP_HI = 16'h3CCF;
  localparam logic [7:0] DEF_FAULT_SETUP = 8'h07;
  localparam logic [7:0] DEF_FAULT_SELECT = 8'h33;
  localparam logic [7:0] DEF_CHECKSUM = 8'hB8;
  localparam logic [7:0] DEF_BLANK = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  // burn timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int WIPE_TIME_US = 8;
  localparam int BURN_TIME_US = 8;
  localparam int QUICK_TIME_US = 2;
  localparam int WIPE_CYC = WIPE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int BURN_CYC = BURN_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int QUICK_CYC = QUICK_TIME_US * 1000 / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// *** core/scrb_nvm_engine.sv ***
// erase and program sequencer for one nonvolatile page
`default_nettype none
module scrb_nvm_engine #(
  parameter int unsigned WIPE_CYC = scrb_pkg::WIPE_CYC,
  parameter int unsigned BURN_CYC = scrb_pkg::BURN_CYC,
  parameter int unsigned QUICK_CYC = scrb_pkg::QUICK_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start_wipe,
  input wire logic start_burn,
  input wire logic start_both,
  input wire logic fixed_time,
  output logic wipe_busy,
  output logic burn_busy,
  output logic wipe_done,
  output logic burn_done
);
  // counter width bounds the longest burn that can be timed
  if (WIPE_CYC < 1 || BURN_CYC < 1 || QUICK_CYC < 1 ||
      WIPE_CYC >= (1 << 24) || BURN_CYC >= (1 << 24) ||
      QUICK_CYC >= (1 << 24)) begin : g_bad_count
    $error("scrb_nvm_engine: cycle counts must lie in 1 .. 2**24-1");
  end

  typedef enum logic [2:0] {
    ENG_IDLE = 3'b001,
    ENG_WIPE = 3'b010,
    ENG_BURN = 3'b100
  } scrb_eng_state_t;

  typedef struct packed {
    scrb_eng_state_t state;
    logic [23:0] cnt;
    logic chain;
    logic fixed;
  } scrb_eng_t;

  scrb_eng_t r;
  scrb_eng_t next_r;

  // fixed timing uses the full period, otherwise the short one
  function automatic logic [23:0] load(input logic fixed, input logic burn);
    int unsigned c;
    c = fixed ? (burn ? BURN_CYC : WIPE_CYC) : QUICK_CYC;
    return 24'(c - 1);
  endfunction

  // a request while a phase runs is dropped
  always_comb begin
    next_r = r;
    wipe_done = 1'b0;
    burn_done = 1'b0;
    unique case (r.state)
      ENG_IDLE: begin
        if (start_wipe || start_both) begin
          next_r.state = ENG_WIPE;
          next_r.cnt = load(fixed_time, 1'b0);
          next_r.chain = start_both;
          next_r.fixed = fixed_time;
        end else if (start_burn) begin
          next_r.state = ENG_BURN;
          next_r.cnt = load(fixed_time, 1'b1);
          next_r.chain = 1'b0;
          next_r.fixed = fixed_time;
        end
      end
      ENG_WIPE: begin
        if (r.cnt == 24'h000000) begin
          wipe_done = 1'b1;
          // combined command runs on into programming
          next_r.state = r.chain ? ENG_BURN : ENG_IDLE;
          next_r.cnt = load(r.fixed, 1'b1);
          next_r.chain = 1'b0;
        end else begin
          next_r.cnt = r.cnt - 24'h000001;
        end
      end
      ENG_BURN: begin
        if (r.cnt == 24'h000000) begin
          burn_done = 1'b1;
          next_r.state = ENG_IDLE;
        end else begin
          next_r.cnt = r.cnt - 24'h000001;
        end
      end
      default: next_r.state = ENG_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '{state: ENG_IDLE, cnt: 24'h000000, chain: 1'b0, fixed: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign wipe_busy = (r.state == ENG_WIPE);
  assign burn_busy = (r.state == ENG_BURN);
endmodule
`default_nettype wire

// *** core/scrb_register_bank.sv ***
// paged control/status register bank with nonvolatile configuration store
// Notes on behaviour
// - The output converter setting defaults to 0x00, absolute voltage.
// - The output stage setting defaults to current-loop mode, 4 to 20 mA.
// - The bridge setting defaults to the code for 2.5 V excitation.
// - The pressure gain defaults to code zero, a gain of 5 V/V.
// - The temperature gain defaults to code zero, a gain of 1.33 V/V.
// - Temperature control defaults to 0x40: no drive, internal input routed.
// - Normal range codes default to 0x0667 and 0x399A, both recalibrated.
// - Clamp codes default to 0x0334 and 0x3CCF, both recalibrated.
// - Fault setup defaults to 0x07: pull resistors on, 10 and 70 % limits.
// - Fault selection defaults to 0x33: input and pressure-amp limits.
// - The four identifier bytes default to zero; the customer writes them.
// - Configuration mode uses live registers, execution mode stored bytes.
// - The combined command wipes the selected page, then writes the cache.
`default_nettype none
module scrb_register_bank #(
  parameter int unsigned WIPE_CYC = scrb_pkg::WIPE_CYC,
  parameter int unsigned BURN_CYC = scrb_pkg::BURN_CYC,
  parameter int unsigned QUICK_CYC = scrb_pkg::QUICK_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [2:0] reg_page,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [15:0] pressure_result,
  input wire logic [15:0] temperature_result,
  input wire logic [7:0] fault_events,
  output logic [1:0] operating_mode,
  output logic [13:0] output_code,
  output logic output_ratiometric,
  output logic [2:0] output_gain,
  output logic current_loop_select,
  output logic output_capacitor_switch,
  output logic [1:0] bridge_excitation_level,
  output logic bridge_supply_switch,
  output logic pressure_polarity_swap,
  output logic [4:0] pressure_gain,
  output logic temperature_polarity_swap,
  output logic [1:0] temperature_gain,
  output logic [2:0] temperature_current_drive,
  output logic [3:0] temperature_input_route,
  output logic temperature_single_ended_select,
  output logic test_output_enable,
  output logic fault_checking_switch,
  output logic [7:0] analog_fault_setup,
  output logic checksum_start,
  output logic wipe_busy,
  output logic burn_busy
);
  typedef struct packed {
    logic [scrb_pkg::MODE_W-1:0] mode;
    logic [scrb_pkg::CODE_W-1:0] code;
    logic [7:0] dac_cfg;
    logic [7:0] op_stage;
    logic [7:0] bridge;
    logic [7:0] pgain;
    logic [7:0] tgain;
    logic [7:0] tchan;
    logic [7:0] fault;
    logic [7:0] test;
    logic [7:0][7:0] cache;
    logic [scrb_pkg::PAGE_W-1:0] page;
    logic fixed;
    logic crc_go;
    logic [127:0][7:0] nvm;
    logic [7:0] eff_dac;
    logic [7:0] eff_op;
    logic [7:0] eff_bridge;
    logic [7:0] eff_pgain;
    logic [7:0] eff_tgain;
    logic [7:0] eff_tchan;
    logic eff_se;
    logic [7:0] rdata;
    logic rvalid;
  } scrb_state_t;

  scrb_state_t r;
  scrb_state_t next_r;
  logic wipe_done;
  logic burn_done;
  logic start_wipe;
  logic start_burn;
  logic start_both;

  // nonvolatile image after power-up, the factory defaults
  function automatic logic [127:0][7:0] nvm_defaults();
    logic [127:0][7:0] m;
    m = '0;
    m[scrb_pkg::NV_DAC_CFG] = scrb_pkg::DEF_DAC_CFG;
    m[scrb_pkg::NV_OP_STAGE] = scrb_pkg::DEF_OP_STAGE;
    m[scrb_pkg::NV_BRIDGE] = scrb_pkg::DEF_BRIDGE;
    m[scrb_pkg::NV_PGAIN] = scrb_pkg::DEF_PGAIN;
    m[scrb_pkg::NV_TGAIN] = scrb_pkg::DEF_TGAIN;
    m[scrb_pkg::NV_TCHAN] = scrb_pkg::DEF_TCHAN;
    m[scrb_pkg::NV_TEMPERATURE_SINGLE_ENDED_SELECT] = scrb_pkg::DEF_BLANK;
    m[scrb_pkg::NV_NORM_LO] = scrb_pkg::DEF_NORM_LO[7:0];
    m[scrb_pkg::NV_NORM_LO + 7'h01] = scrb_pkg::DEF_NORM_LO[15:8];
    m[scrb_pkg::NV_NORM_HI] = scrb_pkg::DEF_NORM_HI[7:0];
    m[scrb_pkg::NV_NORM_HI + 7'h01] = scrb_pkg::DEF_NORM_HI[15:8];
    m[scrb_pkg::NV_CLAMP_LO] = scrb_pkg::DEF_CLAMP_LO[7:0];
    m[scrb_pkg::NV_CLAMP_LO + 7'h01] = scrb_pkg::DEF_CLAMP_LO[15:8];
    m[scrb_pkg::NV_CLAMP_HI] = scrb_pkg::DEF_CLAMP_HI[7:0];
    m[scrb_pkg::NV_CLAMP_HI + 7'h01] = scrb_pkg::DEF_CLAMP_HI[15:8];
    m[scrb_pkg::NV_DIAG_EN] = scrb_pkg::DEF_BLANK;
    m[scrb_pkg::NV_LOCK] = scrb_pkg::DEF_BLANK;
    m[scrb_pkg::NV_FAULT_SETUP] = scrb_pkg::DEF_FAULT_SETUP;
    m[scrb_pkg::NV_FAULT_SELECT] = scrb_pkg::DEF_FAULT_SELECT;
    for (int i = 0; i < 4; i++) begin
      m[scrb_pkg::NV_SERIAL + 7'(i)] = scrb_pkg::DEF_BLANK;
    end
    m[scrb_pkg::NV_CHECKSUM] = scrb_pkg::DEF_CHECKSUM;
    return m;
  endfunction

  // reset state: live registers mirror the stored defaults
  function automatic scrb_state_t reset_state();
    scrb_state_t s;
    s = '0;
    s.nvm = nvm_defaults();
    s.dac_cfg = scrb_pkg::DEF_DAC_CFG;
    s.op_stage = scrb_pkg::DEF_OP_STAGE;
    s.bridge = scrb_pkg::DEF_BRIDGE;
    s.pgain = scrb_pkg::DEF_PGAIN;
    s.tgain = scrb_pkg::DEF_TGAIN;
    s.tchan = scrb_pkg::DEF_TCHAN;
    s.eff_dac = scrb_pkg::DEF_DAC_CFG;
    s.eff_op = scrb_pkg::DEF_OP_STAGE;
    s.eff_bridge = scrb_pkg::DEF_BRIDGE;
    s.eff_pgain = scrb_pkg::DEF_PGAIN;
    s.eff_tgain = scrb_pkg::DEF_TGAIN;
    s.eff_tchan = scrb_pkg::DEF_TCHAN;
    return s;
  endfunction

  // page and offset match, shared by the write and read decoders
  function automatic logic hit(input logic [2:0] pg, input logic [7:0] ad,
                               input logic [2:0] want_pg,
                               input logic [7:0] want_ad);
    return (pg == want_pg) && (ad == want_ad);
  endfunction

  localparam logic [2:0] P0 = scrb_pkg::PAGE_CTRL;
  localparam logic [2:0] P2 = scrb_pkg::PAGE_CONV;
  localparam logic [2:0] P5 = scrb_pkg::PAGE_NVM;

  // program commands only start the sequencer; the bits never store
  assign start_burn = reg_write && hit(reg_page, reg_addr, P5,
                      scrb_pkg::OFS_PROG) && reg_wdata[scrb_pkg::PROG_BURN_BIT];
  assign start_wipe = reg_write && hit(reg_page, reg_addr, P5,
                      scrb_pkg::OFS_PROG) && reg_wdata[scrb_pkg::PROG_WIPE_BIT];
  assign start_both = reg_write && hit(reg_page, reg_addr, P5,
                      scrb_pkg::OFS_PROG) && reg_wdata[scrb_pkg::PROG_BOTH_BIT];

  scrb_nvm_engine #(
    .WIPE_CYC(WIPE_CYC),
    .BURN_CYC(BURN_CYC),
    .QUICK_CYC(QUICK_CYC)
  ) u_engine (
    .clk(clk),
    .reset_n(reset_n),
    .start_wipe(start_wipe),
    .start_burn(start_burn),
    .start_both(start_both),
    .fixed_time(r.fixed),
    .wipe_busy(wipe_busy),
    .burn_busy(burn_busy),
    .wipe_done(wipe_done),
    .burn_done(burn_done)
  );

  // register writes, page burns, fault capture and the read answer
  always_comb begin
    logic cfg_mode;
    logic busy;
    logic [7:0] rv;
    logic [7:0] clr;
    logic [6:0] base;
    cfg_mode = (r.mode != scrb_pkg::MODE_EXECUTE);
    busy = wipe_busy || burn_busy;
    rv = 8'h00;
    clr = 8'h00;
    base = {r.page, 3'h0};
    next_r = r;
    next_r.crc_go = 1'b0;
    if (reg_write) begin
      // read-only offsets fall through untouched
      if (hit(reg_page, reg_addr, P0, scrb_pkg::OFS_MODE))
        next_r.mode = reg_wdata[scrb_pkg::MODE_W-1:0];
      if (hit(reg_page, reg_addr, P2, scrb_pkg::OFS_CODE_LO))
        next_r.code[7:0] = reg_wdata;
      if (hit(reg_page, reg_addr, P2, scrb_pkg::OFS_CODE_HI))
        next_r.code[13:8] = reg_wdata[5:0];
      if (hit(reg_page, reg_addr, P2, scrb_pkg::OFS_DAC_CFG))
        next_r.dac_cfg = reg_wdata;
      if (hit(reg_page, reg_addr, P2, scrb_pkg::OFS_OP_STAGE))
        next_r.op_stage = reg_wdata;
      if (hit(reg_page, reg_addr, P2, scrb_pkg::OFS_BRIDGE))
        next_r.bridge = reg_wdata;
      if (hit(reg_page, reg_addr, P2, scrb_pkg::OFS_PGAIN))
        next_r.pgain = reg_wdata;
      if (hit(reg_page, reg_addr, P2, scrb_pkg::OFS_TGAIN))
        next_r.tgain = reg_wdata;
      if (hit(reg_page, reg_addr, P2, scrb_pkg::OFS_TCHAN))
        next_r.tchan = reg_wdata;
      if (hit(reg_page, reg_addr, P2, scrb_pkg::OFS_FAULT))
        clr = reg_wdata; // write one to clear
      if (hit(reg_page, reg_addr, P2, scrb_pkg::OFS_TEST))
        next_r.test = reg_wdata & scrb_pkg::TEST_MASK;
      // cache and page stay frozen while a burn uses them
      if (reg_page == P5 && reg_addr >= scrb_pkg::OFS_CACHE &&
          reg_addr <= scrb_pkg::OFS_CACHE_END && !busy)
        next_r.cache[reg_addr[2:0]] = reg_wdata;
      if (hit(reg_page, reg_addr, P5, scrb_pkg::OFS_PAGE) && !busy)
        next_r.page = reg_wdata[scrb_pkg::PAGE_W-1:0];
      if (hit(reg_page, reg_addr, P5, scrb_pkg::OFS_PROG))
        next_r.fixed = reg_wdata[scrb_pkg::PROG_FIXED_BIT];
      if (hit(reg_page, reg_addr, P5, scrb_pkg::OFS_CHECKSUM))
        next_r.crc_go = reg_wdata[0];
    end
    // a new fault wins over a clear in the same cycle
    next_r.fault = ((r.fault & ~clr) |
                    (fault_events & r.nvm[scrb_pkg::NV_FAULT_SELECT])) &
                   scrb_pkg::FAULT_MASK;
    // erase then program the selected page
    for (int i = 0; i < 8; i++) begin
      if (wipe_done)
        next_r.nvm[base + 7'(i)] = scrb_pkg::ERASED_BYTE;
      if (burn_done)
        next_r.nvm[base + 7'(i)] = r.cache[i];
    end
    // live registers in configuration mode, stored bytes otherwise
    next_r.eff_dac = cfg_mode ? r.dac_cfg : r.nvm[scrb_pkg::NV_DAC_CFG];
    next_r.eff_op = cfg_mode ? r.op_stage : r.nvm[scrb_pkg::NV_OP_STAGE];
    next_r.eff_bridge = cfg_mode ? r.bridge : r.nvm[scrb_pkg::NV_BRIDGE];
    next_r.eff_pgain = cfg_mode ? r.pgain : r.nvm[scrb_pkg::NV_PGAIN];
    next_r.eff_tgain = cfg_mode ? r.tgain : r.nvm[scrb_pkg::NV_TGAIN];
    next_r.eff_tchan = cfg_mode ? r.tchan : r.nvm[scrb_pkg::NV_TCHAN];
    next_r.eff_se = cfg_mode ? r.test[scrb_pkg::TEST_SE_BIT]
                             : r.nvm[scrb_pkg::NV_TEMPERATURE_SINGLE_ENDED_SELECT][0];
    // read mux; unmapped offsets answer zero
    if (reg_page == P5 && reg_addr <= scrb_pkg::OFS_WINDOW_END)
      rv = r.nvm[reg_addr[6:0]];
    else if (reg_page == P5 && reg_addr >= scrb_pkg::OFS_CACHE &&
             reg_addr <= scrb_pkg::OFS_CACHE_END)
      rv = r.cache[reg_addr[2:0]];
    else if (hit(reg_page, reg_addr, P5, scrb_pkg::OFS_PAGE))
      rv = {4'h0, r.page};
    else if (hit(reg_page, reg_addr, P5, scrb_pkg::OFS_PROG))
      rv = {4'h0, r.fixed, 3'h0};
    else if (hit(reg_page, reg_addr, P5, scrb_pkg::OFS_BUSY))
      rv = {5'h00, burn_busy, wipe_busy, 1'b0};
    else if (hit(reg_page, reg_addr, P0, scrb_pkg::OFS_MODE))
      rv = {6'h00, r.mode};
    else if (hit(reg_page, reg_addr, P2, scrb_pkg::OFS_PRES_LO))
      rv = pressure_result[7:0];
    else if (hit(reg_page, reg_addr, P2, scrb_pkg::OFS_PRES_HI))
      rv = pressure_result[15:8];
    else if (hit(reg_page, reg_addr, P2, scrb_pkg::OFS_TEMP_LO))
      rv = temperature_result[7:0];
    else if (hit(reg_page, reg_addr, P2, scrb_pkg::OFS_TEMP_HI))
      rv = temperature_result[15:8];
    else if (hit(reg_page, reg_addr, P2, scrb_pkg::OFS_CODE_LO))
      rv = r.code[7:0];
    else if (hit(reg_page, reg_addr, P2, scrb_pkg::OFS_CODE_HI))
      rv = {2'h0, r.code[13:8]};
    else if (hit(reg_page, reg_addr, P2, scrb_pkg::OFS_DAC_CFG))
      rv = r.dac_cfg;
    else if (hit(reg_page, reg_addr, P2, scrb_pkg::OFS_OP_STAGE))
      rv = r.op_stage;
    else if (hit(reg_page, reg_addr, P2, scrb_pkg::OFS_BRIDGE))
      rv = r.bridge;
    else if (hit(reg_page, reg_addr, P2, scrb_pkg::OFS_PGAIN))
      rv = r.pgain;
    else if (hit(reg_page, reg_addr, P2, scrb_pkg::OFS_TGAIN))
      rv = r.tgain;
    else if (hit(reg_page, reg_addr, P2, scrb_pkg::OFS_TCHAN))
      rv = r.tchan;
    else if (hit(reg_page, reg_addr, P2, scrb_pkg::OFS_FAULT))
      rv = r.fault;
    else if (hit(reg_page, reg_addr, P2, scrb_pkg::OFS_TEST))
      rv = r.test;
    next_r.rvalid = reg_read;
    next_r.rdata = reg_read ? rv : r.rdata;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= reset_state();
    end else begin
      r <= next_r;
    end
  end

  // outputs are slices of registered state
  assign reg_rdata = r.rdata;
  assign reg_rvalid = r.rvalid;
  assign operating_mode = r.mode;
  assign output_code = r.code;
  assign output_ratiometric = r.eff_dac[0];
  assign output_gain = r.eff_op[2:0];
  assign current_loop_select = r.eff_op[3];
  assign output_capacitor_switch = r.eff_op[4];
  assign bridge_excitation_level = r.eff_bridge[2:1];
  assign bridge_supply_switch = r.eff_bridge[0];
  assign pressure_polarity_swap = r.eff_pgain[7];
  assign pressure_gain = r.eff_pgain[4:0];
  assign temperature_polarity_swap = r.eff_tgain[7];
  assign temperature_gain = r.eff_tgain[1:0];
  assign temperature_current_drive = r.eff_tchan[6:4];
  assign temperature_input_route = r.eff_tchan[3:0];
  assign temperature_single_ended_select = r.eff_se;
  assign test_output_enable = r.test[scrb_pkg::TEST_DAC_BIT];
  assign fault_checking_switch = r.nvm[scrb_pkg::NV_DIAG_EN][0];
  assign analog_fault_setup = r.nvm[scrb_pkg::NV_FAULT_SETUP];
  assign checksum_start = r.crc_go;
endmodule
`default_nettype wire

// *** sim/scrb_register_bank_assertions.sv ***
// port checker for the sensor conditioner register bank
`default_nettype none
module scrb_register_bank_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [2:0] reg_page,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [15:0] pressure_result,
  input wire logic [1:0] operating_mode,
  input wire logic current_loop_select,
  input wire logic [2:0] temperature_current_drive,
  input wire logic [3:0] temperature_input_route,
  input wire logic [7:0] analog_fault_setup,
  input wire logic wipe_busy,
  input wire logic burn_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic idle;
  assign idle = !wipe_busy && !burn_busy; // free to take a command
  AST_LOOP_DEFAULT: assert property ($rose(reset_n) |->
    current_loop_select) else $error("loop mode not default after reset");
  AST_TCHAN_DEFAULT: assert property ($rose(reset_n) |->
    temperature_current_drive == 3'h4 && temperature_input_route == 4'h0)
    else $error("temperature channel default wrong");
  AST_SETUP_DEFAULT: assert property ($rose(reset_n) |->
    analog_fault_setup == 8'h07) else $error("fault setup default wrong");
  AST_MODE_WRITE: assert property (reg_write && reg_page == 3'h0 &&
    reg_addr == 8'h0C |=> operating_mode == $past(reg_wdata[1:0]))
    else $error("mode field not updated");
  AST_COMBINED_START: assert property (reg_write && reg_page == 3'h5 &&
    reg_addr == 8'h89 && reg_wdata[2] && idle |=> wipe_busy && !burn_busy)
    else $error("combined command did not start with erase");
  AST_BUSY_EXCL: assert property (!(wipe_busy && burn_busy))
    else $error("erase and program busy together");
  AST_RO_PRESSURE: assert property (reg_read && reg_page == 3'h2 &&
    reg_addr == 8'h20 |=> reg_rdata == $past(pressure_result[7:0]))
    else $error("pressure low byte read wrong");
  AST_BUSY_READ: assert property (reg_read && reg_page == 3'h5 &&
    reg_addr == 8'h8B |=> reg_rdata == {5'h00, $past(burn_busy),
    $past(wipe_busy), 1'b0}) else $error("busy status read wrong");
endmodule
bind scrb_register_bank scrb_register_bank_checker i_checker (
  .clk(clk), .reset_n(reset_n), .reg_page(reg_page), .reg_addr(reg_addr),
  .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .pressure_result(pressure_result),
  .operating_mode(operating_mode), .current_loop_select(current_loop_select),
  .temperature_current_drive(temperature_current_drive),
  .temperature_input_route(temperature_input_route),
  .analog_fault_setup(analog_fault_setup), .wipe_busy(wipe_busy),
  .burn_busy(burn_busy));
`default_nettype wire

// *** sim/scrb_master_model.sv ***
// calibration master model that drives the register port
`default_nettype none
module scrb_master_model (
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  output logic [2:0] reg_page,
  output logic [7:0] reg_addr,
  output logic reg_write,
  output logic reg_read,
  output logic [7:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_page = 3'h0;
    reg_addr = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_wdata = 8'h00;
  end
  // configuration reaches the stored bytes only through these writes
  task automatic wr(input logic [2:0] pg, input logic [7:0] ad,
                    input logic [7:0] d);
    @(negedge clk);
    reg_page = pg;
    reg_addr = ad;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clk);
    reg_write = 1'b0;
    reg_wdata = ~d; // stale data must not look valid
  endtask
  // answer is due exactly one cycle after the request edge
  task automatic rd(input logic [2:0] pg, input logic [7:0] ad,
                    output logic [7:0] d, output logic ok);
    @(negedge clk);
    reg_page = pg;
    reg_addr = ad;
    reg_read = 1'b1;
    @(negedge clk);
    reg_read = 1'b0;
    ok = reg_rvalid;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// *** sim/tb_sensor_conditioner_register_bank.sv ***
// testbench of the sensor conditioner register bank
`default_nettype none
module tb_sensor_conditioner_register_bank;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset_n, reg_write, reg_read, reg_rvalid, wb, bb, rat, cls, ps;
  logic [2:0] reg_page;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, afs, d, fe;
  logic [1:0] bel, tg, mode;
  logic [4:0] pg;
  logic [2:0] tcd;
  logic [3:0] tir;
  int err_total = 0;
  int num_checks = 0;
  scrb_register_bank #(.WIPE_CYC(4), .BURN_CYC(4), .QUICK_CYC(2)) i_dut (
    .clk(clk), .reset_n(reset_n), .reg_page(reg_page), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .pressure_result(16'h1234), .temperature_result(16'h5678),
    .fault_events(fe), .operating_mode(mode), .output_code(),
    .output_ratiometric(rat), .output_gain(), .current_loop_select(cls),
    .output_capacitor_switch(), .bridge_excitation_level(bel),
    .bridge_supply_switch(), .pressure_polarity_swap(ps),
    .pressure_gain(pg), .temperature_polarity_swap(),
    .temperature_gain(tg), .temperature_current_drive(tcd),
    .temperature_input_route(tir), .temperature_single_ended_select(),
    .test_output_enable(), .fault_checking_switch(),
    .analog_fault_setup(afs), .checksum_start(), .wipe_busy(wb),
    .burn_busy(bb));
  scrb_master_model m (.clk(clk), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_page(reg_page), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata));
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    num_checks++;
    if (seen !== want) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic rchk(input logic [2:0] p, input logic [7:0] a,
                      input logic [7:0] want);
    logic ok;
    m.rd(p, a, d, ok);
    check({15'h0000, ok}, 16'h0001);
    check({8'h00, d}, {8'h00, want});
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // live outputs first, then the stored defaults as read through the window
  task automatic t_defaults;
    logic [7:0] a [20] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h29,
      8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h2F, 8'h30, 8'h33, 8'h34, 8'h38,
      8'h3B, 8'h7F, 8'h39};
    logic [7:0] v [20] = '{8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h40, 8'h67,
      8'h06, 8'h9A, 8'h39, 8'h34, 8'h03, 8'hCF, 8'h3C, 8'h07, 8'h33, 8'h00,
      8'h00, 8'hB8, 8'h00};
    check({14'h0000, rat, cls}, 16'h0001);
    check({7'h00, bel, pg, tg}, 16'h0000);
    check({9'h000, tcd, tir}, 16'h0040);
    check({8'h00, afs}, 16'h0007);
    foreach (a[i]) rchk(3'h5, a[i], v[i]);
    $display("test defaults done");
  endtask
  // read-only places keep their contents after a write
  task automatic t_readonly;
    m.wr(3'h2, 8'h20, 8'h5A);
    rchk(3'h2, 8'h20, 8'h34);
    rchk(3'h2, 8'h21, 8'h12);
    m.wr(3'h5, 8'h10, 8'hFF);
    rchk(3'h5, 8'h10, 8'h00);
    m.wr(3'h5, 8'h8B, 8'hFF);
    rchk(3'h5, 8'h8B, 8'h00);
    // a new fault beats a clear in the same cycle, then one-bits clear
    fe = 8'hFF;
    m.wr(3'h2, 8'h5A, 8'hFF);
    fe = 8'h00;
    rchk(3'h2, 8'h5A, 8'h33);
    m.wr(3'h2, 8'h5A, 8'h30);
    rchk(3'h2, 8'h5A, 8'h03);
    $display("test readonly done");
  endtask
  // configuration mode applies live settings, execution the stored ones
  task automatic t_mode;
    m.wr(3'h0, 8'h0C, 8'h01);
    m.wr(3'h2, 8'h47, 8'h85);
    repeat (2) @(negedge clk);
    check({10'h000, ps, pg}, 16'h0025);
    m.wr(3'h0, 8'h0C, 8'h00);
    repeat (2) @(negedge clk);
    check({10'h000, ps, pg}, 16'h0000);
    $display("test mode done");
  endtask
  // combined erase and program of the identifier page from the cache
  task automatic t_burn;
    int n;
    m.wr(3'h5, 8'h88, 8'h07);
    for (int i = 0; i < 8; i++) m.wr(3'h5, 8'h80 + 8'(i), 8'h11 * 8'(i + 1));
    m.wr(3'h5, 8'h89, 8'h04);
    check({14'h0000, wb, bb}, 16'h0002);
    n = 0;
    while ((wb || bb) && n < 100) begin
      @(negedge clk);
      n++;
    end
    check({15'h0000, n < 100}, 16'h0001);
    if (n == 100) test_done();
    for (int i = 0; i < 8; i++)
      rchk(3'h5, 8'h38 + 8'(i), 8'h11 * 8'(i + 1));
    $display("test burn done");
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    reset_n = 1'b0;
    fe = 8'h00;
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    t_defaults();
    t_readonly();
    t_mode();
    t_burn();
    test_done();
  end
endmodule
`default_nettype wire
